// *** hdl/iobd_top.sv ***
/*
  Device side of a peripheral on the processor I/O bus: select decode,
  busy/done flags, priority interrupt request, APB register file.
  Assumes the processor bus and APB share REF_CLK; the processor keeps its
  own sequencing of data transfers.
*/
// The register offsets and register access over APB were left to the implementer.
`timescale 1ns/1ps
`include "iobd_cfg.svh"

module iobd_top #(
  parameter int UNIT_CYCLES = (`IOBD_UNIT_TIME_NS + `IOBD_CLK_PERIOD_NS - 1) /
                              `IOBD_CLK_PERIOD_NS,
  parameter logic [6:0] CODE_RST = `IOBD_CODE_RST
) (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RST,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [`IOBD_ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Processor I/O bus
  input wire logic IO_STROBE,
  input wire logic [1:0] IO_FUNC,
  input wire logic [`IOBD_WORD_W-1:0] IO_INSTR,
  input wire logic [`IOBD_WORD_W-1:0] IO_WDATA,
  output logic IO_ACK,
  output logic [`IOBD_WORD_W-1:0] IO_RDATA,
  // Priority interrupt requests, bit n is level n+1
  output logic [6:0] PI_REQ,
  // Unit data side
  output logic [`IOBD_WORD_W-1:0] UNIT_OUT_DATA,
  output logic UNIT_OUT_VALID,
  input wire logic [`IOBD_WORD_W-1:0] UNIT_IN_DATA,
  // Interrupt
  output logic IRQ
);

  // ==========================================================================
  // Functions
  function automatic logic [6:0] chan_req(input logic [2:0] ch);
    chan_req = 7'h00;
    if (ch != `IOBD_CH_NONE)
      chan_req[ch - 3'h1] = 1'b1;
  endfunction : chan_req

  function automatic logic [31:0] status_word(input logic busy, input logic done,
                                              input logic [2:0] ch, input logic dir);
    status_word = 32'h0000_0000;
    status_word[`IOBD_ST_BUSY] = busy;
    status_word[`IOBD_ST_DONE] = done;
    status_word[`IOBD_ST_CH_HI:`IOBD_ST_CH_LO] = ch;
    status_word[`IOBD_ST_DIR] = dir;
  endfunction : status_word

  // ==========================================================================
  // State
  iobd_pkg::iobd_state_e state;
  iobd_pkg::iobd_state_e next_state;
  logic [6:0] dev_code;
  logic [2:0] channel;
  logic dir_out;
  logic [`IOBD_WORD_W-1:0] out_buf;
  logic [`IOBD_WORD_W-1:0] in_buf;
  logic [`IOBD_EVT_W-1:0] evt;
  logic [`IOBD_EVT_W-1:0] mask;

  iobd_unit_if unit_bus ();

  iobd_unit #(
    .CYCLES(UNIT_CYCLES)
  ) u_unit (
    .clk(REF_CLK),
    .rst(RST),
    .u(unit_bus)
  );

  // ==========================================================================
  // Processor bus decode
  wire sel_match = IO_INSTR[`IOBD_SEL_HI:`IOBD_SEL_LO] == dev_code;
  wire op = IO_STROBE && sel_match;
  wire op_conditions_out_write = op && (IO_FUNC == iobd_pkg::IOBD_FN_CONDITIONS_OUT_WRITE);
  wire op_dato = op && (IO_FUNC == iobd_pkg::IOBD_FN_DATO);
  wire op_dati = op && (IO_FUNC == iobd_pkg::IOBD_FN_DATI);
  wire op_coni = op && (IO_FUNC == iobd_pkg::IOBD_FN_CONI);
  wire is_busy = state == iobd_pkg::IOBD_BUSY;
  wire is_done = state == iobd_pkg::IOBD_DONE;
  // A conditions-out takes its new direction before the start is judged
  wire conditions_out_write_dir = IO_WDATA[`IOBD_CONDITIONS_OUT_WRITE_DIR];
  wire conditions_out_write_start = op_conditions_out_write && IO_WDATA[`IOBD_CONDITIONS_OUT_WRITE_START];
  wire dato_go = op_dato && dir_out;
  // Work already in progress is never restarted; a data-out then is an overrun
  wire go = (conditions_out_write_start || dato_go) && !is_busy;
  wire overrun = op_dato && is_busy;
  wire finish = unit_bus.finish;
  wire [31:0] stat = status_word(is_busy, is_done, channel, dir_out);

  assign unit_bus.start = go;

  // ==========================================================================
  // Busy/done sequencing
  always_comb
  begin
    next_state = state;
    case (state)
      iobd_pkg::IOBD_IDLE:
        if (go)
          next_state = iobd_pkg::IOBD_BUSY;
      iobd_pkg::IOBD_BUSY:
        if (finish)
          next_state = iobd_pkg::IOBD_DONE;
      iobd_pkg::IOBD_DONE:
        if (go)
          next_state = iobd_pkg::IOBD_BUSY;
        else if (op_dati || op_dato)
          next_state = iobd_pkg::IOBD_IDLE;
      default:
        next_state = iobd_pkg::IOBD_IDLE;
    endcase
  end

  always_ff @(posedge REF_CLK)
  begin
    if (RST)
      state <= iobd_pkg::IOBD_IDLE;
    else
      state <= next_state;
  end

  // ==========================================================================
  // Conditions and data buffers
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      channel <= `IOBD_CH_NONE;
      dir_out <= 1'b0;
    end
    else if (op_conditions_out_write)
    begin
      channel <= IO_WDATA[`IOBD_CONDITIONS_OUT_WRITE_CH_HI:`IOBD_CONDITIONS_OUT_WRITE_CH_LO];
      dir_out <= conditions_out_write_dir;
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      out_buf <= '0;
      in_buf <= '0;
    end
    else
    begin
      if (dato_go && !is_busy)
        out_buf <= IO_WDATA;
      if (finish && !dir_out)
        in_buf <= UNIT_IN_DATA;
    end
  end

  // ==========================================================================
  // Processor bus answers and unit output
  wire [`IOBD_WORD_W-1:0] next_rdata = op_dati ? in_buf :
                                       op_coni ? `IOBD_WORD_W'(stat) : '0;

  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      IO_ACK <= 1'b0;
      IO_RDATA <= '0;
      UNIT_OUT_DATA <= '0;
      UNIT_OUT_VALID <= 1'b0;
    end
    else
    begin
      IO_ACK <= op;
      IO_RDATA <= next_rdata;
      UNIT_OUT_DATA <= out_buf;
      UNIT_OUT_VALID <= finish && dir_out;
    end
  end

  // ==========================================================================
  // Priority interrupt request
  // Level 0 is never driven, so a zero channel simply means polling
  wire next_pi_on = next_state == iobd_pkg::IOBD_DONE;
  wire [6:0] next_pi_req = next_pi_on ? chan_req(channel) : 7'h00;

  always_ff @(posedge REF_CLK)
  begin
    if (RST)
      PI_REQ <= 7'h00;
    else
      PI_REQ <= next_pi_req;
  end

  // ==========================================================================
  // APB slave: one wait state, so every access completes in three cycles
  wire access = PSEL && PENABLE;
  wire fire = access && PREADY;
  wire wr_fire = fire && PWRITE;
  wire hit_config = PADDR == `IOBD_OFF_CONFIG;
  wire hit_status = PADDR == `IOBD_OFF_STATUS;
  wire hit_event = PADDR == `IOBD_OFF_EVENT;
  wire hit_mask = PADDR == `IOBD_OFF_MASK;
  wire mapped = hit_config || hit_status || hit_event || hit_mask;
  wire [31:0] rd_mux = hit_config ? {25'h0000000, dev_code} :
                       hit_status ? stat :
                       hit_event ? {30'h00000000, evt} :
                       hit_mask ? {30'h00000000, mask} : 32'h0000_0000;

  // Hardware set wins over a software clear in the same cycle
  wire [`IOBD_EVT_W-1:0] evt_set = {overrun, finish};
  wire [`IOBD_EVT_W-1:0] evt_clr = (wr_fire && hit_event) ? PWDATA[`IOBD_EVT_W-1:0] : '0;
  wire [`IOBD_EVT_W-1:0] next_evt = (evt & ~evt_clr) | evt_set;
  wire [`IOBD_EVT_W-1:0] next_mask = (wr_fire && hit_mask) ? PWDATA[`IOBD_EVT_W-1:0] : mask;

  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      PREADY <= 1'b0;
      PRDATA <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end
    else
    begin
      PREADY <= access && !PREADY;
      PSLVERR <= access && !PREADY && !mapped;
      if (access && !PREADY && !PWRITE)
        PRDATA <= rd_mux;
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (RST)
      dev_code <= CODE_RST;
    else if (wr_fire && hit_config)
      dev_code <= PWDATA[6:0];
  end

  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      evt <= '0;
      mask <= '0;
      IRQ <= 1'b0;
    end
    else
    begin
      evt <= next_evt;
      mask <= next_mask;
      IRQ <= |(next_evt & next_mask);
    end
  end

endmodule : iobd_top

// *** hdl/iobd_cfg.svh ***
/*
  Constants of the I/O bus device controller: field positions, register offsets,
  reset values and timing figures.
  Assumes it is included by bare name wherever a constant is needed.
*/
`ifndef IOBD_CFG_SVH
`define IOBD_CFG_SVH

// ==========================================================================
// Processor I/O bus fields
// Instruction bits are numbered from the most significant end, so bit 03..09
// of a 36-bit word sit at vector positions 32..26.
`define IOBD_WORD_W 36
`define IOBD_SEL_HI 32
`define IOBD_SEL_LO 26
`define IOBD_CONDITIONS_OUT_WRITE_CH_HI 2
`define IOBD_CONDITIONS_OUT_WRITE_CH_LO 0
`define IOBD_CONDITIONS_OUT_WRITE_DIR 3
`define IOBD_CONDITIONS_OUT_WRITE_START 4
`define IOBD_CH_NONE 3'h0

// ==========================================================================
// Register map, byte addresses
`define IOBD_ADDR_W 12
`define IOBD_OFF_CONFIG 12'h000
`define IOBD_OFF_STATUS 12'h004
`define IOBD_OFF_EVENT 12'h008
`define IOBD_OFF_MASK 12'h00c
`define IOBD_CODE_RST 7'h00

// ==========================================================================
// Status word and event bits
`define IOBD_ST_BUSY 0
`define IOBD_ST_DONE 1
`define IOBD_ST_CH_LO 2
`define IOBD_ST_CH_HI 4
`define IOBD_ST_DIR 5
`define IOBD_EVT_W 2
`define IOBD_EVT_DONE 0
`define IOBD_EVT_OVR 1

// ==========================================================================
// Timing: processing time of one unit of data
`define IOBD_UNIT_TIME_NS 1000
`define IOBD_CLK_PERIOD_NS 25

`endif

// *** hdl/iobd_pkg.sv ***
/*
  Types of the I/O bus device controller.
  Assumes iobd_cfg.svh supplies the numeric constants.
*/
package iobd_pkg;

  // ==========================================================================
  // Device state, one-hot
  typedef enum logic [2:0] {
    IOBD_IDLE = 3'h1,
    IOBD_BUSY = 3'h2,
    IOBD_DONE = 3'h4
  } iobd_state_e;

  // ==========================================================================
  // Processor I/O bus operation codes
  typedef enum logic [1:0] {
    IOBD_FN_CONDITIONS_OUT_WRITE = 2'h0,
    IOBD_FN_DATO = 2'h1,
    IOBD_FN_DATI = 2'h2,
    IOBD_FN_CONI = 2'h3
  } iobd_func_e;

endpackage : iobd_pkg

// *** hdl/iobd_unit_if.sv ***
/*
  Handshake between the controller and its unit timing engine.
  Assumes both ends share one clock.
*/
`timescale 1ns/1ps

interface iobd_unit_if;
  logic start;
  logic finish;
  modport ctrl (output start, input finish);
  modport engine (input start, output finish);
endinterface : iobd_unit_if

// *** hdl/iobd_unit.sv ***
/*
  Unit engine: models the time the device spends on one unit of data and
  pulses finish once that time has passed.
  Assumes start is a one-cycle pulse given only while the engine is idle.
*/
`timescale 1ns/1ps

module iobd_unit #(
  parameter int CYCLES = 40
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control side
  iobd_unit_if.engine u
);

  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  logic run;
  logic [CW-1:0] count;
  logic fin;

  wire at_end = run && (count == LAST);

  assign u.finish = fin;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      run <= 1'b0;
      count <= '0;
      fin <= 1'b0;
    end
    else
    begin
      fin <= at_end;
      if (u.start)
      begin
        run <= 1'b1;
        count <= '0;
      end
      else if (at_end)
        run <= 1'b0;
      else if (run)
        count <= count + CW'(1);
    end
  end

endmodule : iobd_unit

// *** tb/iobd_props.sv ***
/*
  Checker for the I/O bus device: bus answers, select decode, interrupt requests.
  Assumes it is bound to iobd_top and sees only that module's ports.
*/
`timescale 1ns/1ps
`include "iobd_cfg.svh"

module iobd_props #(
  parameter int UNIT_CYCLES = 40,
  parameter logic [6:0] CODE_RST = 7'h00
) (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RST,
  // APB
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [`IOBD_ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // Processor bus and requests
  input wire logic IO_STROBE,
  input wire logic [1:0] IO_FUNC,
  input wire logic [`IOBD_WORD_W-1:0] IO_INSTR,
  input wire logic [`IOBD_WORD_W-1:0] IO_WDATA,
  input wire logic IO_ACK,
  input wire logic [`IOBD_WORD_W-1:0] IO_RDATA,
  input wire logic [6:0] PI_REQ,
  input wire logic UNIT_OUT_VALID
);
  // ==========================================================================
  // Shadow copies of code and channel, so the checker needs no internal probes
  logic [6:0] code;
  logic [2:0] chan;
  wire logic sel = IO_STROBE && (IO_INSTR[`IOBD_SEL_HI:`IOBD_SEL_LO] == code);
  wire logic code_wr = PSEL && PENABLE && PREADY && PWRITE && (PADDR == `IOBD_OFF_CONFIG);
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      code <= CODE_RST;
      chan <= 3'h0;
    end
    else
    begin
      if (code_wr)
        code <= PWDATA[6:0];
      if (sel && IO_FUNC == 2'h0)
        chan <= IO_WDATA[2:0];
    end
  end

  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);

  // ==========================================================================
  // Properties
  property p_sel_ack; sel |=> IO_ACK; endproperty
  a_sel_ack: assert property (p_sel_ack) else $error("selected op not acknowledged");
  property p_unsel; IO_STROBE && !sel |=> !IO_ACK; endproperty
  a_unsel: assert property (p_unsel) else $error("foreign op acknowledged");
  property p_rzero; sel && !IO_FUNC[1] |=> IO_RDATA == 36'h0; endproperty
  a_rzero: assert property (p_rzero) else $error("write op returned data");
  property p_onehot; $onehot0(PI_REQ); endproperty
  a_onehot: assert property (p_onehot) else $error("request on two levels");
  property p_req; UNIT_OUT_VALID && chan != 3'h0 |=> PI_REQ == (7'h01 << (chan - 3'h1));
  endproperty
  a_req: assert property (p_req) else $error("done without request");
  property p_poll; UNIT_OUT_VALID && chan == 3'h0 |=> PI_REQ == 7'h00; endproperty
  a_poll: assert property (p_poll) else $error("request with no channel");
  property p_drop; sel && (IO_FUNC == 2'h1 || IO_FUNC == 2'h2) |=> ##1 PI_REQ == 7'h00;
  endproperty
  a_drop: assert property (p_drop) else $error("request kept after service");
  property p_wait; PSEL && !PENABLE |=> !PREADY ##1 PREADY; endproperty
  a_wait: assert property (p_wait) else $error("wrong APB wait");
  property p_pulse; PREADY |=> !PREADY; endproperty
  a_pulse: assert property (p_pulse) else $error("ready held");
  property p_err; PSLVERR |-> PREADY && (PADDR > 12'h00c || PADDR[1:0] != 2'h0); endproperty
  a_err: assert property (p_err) else $error("error on mapped address");
  c_req: cover property (UNIT_OUT_VALID && chan != 3'h0);
  c_err: cover property (PSLVERR);
  c_unsel: cover property (IO_STROBE && !sel);
  c_poll: cover property (UNIT_OUT_VALID && chan == 3'h0);
endmodule : iobd_props

bind iobd_top iobd_props #(.UNIT_CYCLES(UNIT_CYCLES), .CODE_RST(CODE_RST)) iobd_props_i (
  .REF_CLK(REF_CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .IO_STROBE(IO_STROBE), .IO_FUNC(IO_FUNC), .IO_INSTR(IO_INSTR), .IO_WDATA(IO_WDATA),
  .IO_ACK(IO_ACK), .IO_RDATA(IO_RDATA), .PI_REQ(PI_REQ), .UNIT_OUT_VALID(UNIT_OUT_VALID));

// *** tb/iobd_cpu.sv ***
/*
  Processor model: issues one I/O operation at a time on the processor bus.
  Assumes the device answers one cycle after the strobe edge.
*/
`timescale 1ns/1ps

module iobd_cpu (
  // Clock
  input wire logic clk,
  // Processor bus
  output logic io_strobe,
  output logic [1:0] io_func,
  output logic [35:0] io_instr,
  output logic [35:0] io_wdata,
  input wire logic io_ack,
  input wire logic [35:0] io_rdata
);
  initial
  begin
    io_strobe = 1'b0;
    io_func = 2'h0;
    io_instr = 36'h0;
    io_wdata = 36'h0;
  end

  // One word per op; released lines are inverted so stale values never match
  task automatic op(input logic [1:0] fn, input logic [6:0] code, input logic [35:0] wd,
                    output logic ack, output logic [35:0] rd);
    @(posedge clk);
    io_strobe <= 1'b1;
    io_func <= fn;
    io_instr <= {3'h0, code, 26'h0};
    io_wdata <= wd;
    @(posedge clk);
    io_strobe <= 1'b0;
    io_func <= ~fn;
    io_instr <= ~io_instr;
    io_wdata <= ~wd;
    // The answer stands only in the cycle after the taking edge
    @(negedge clk);
    ack = io_ack;
    rd = io_rdata;
  endtask : op
endmodule : iobd_cpu

// *** tb/tb_iobd_top.sv ***
/*
  Testbench of the I/O bus device: APB register tasks and processor ops.
  Assumes the design's cfg header and a small unit time.
*/
`timescale 1ns/1ps
`include "iobd_cfg.svh"

module tb_iobd_top;
  localparam int UC = 4;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rr;
  logic pready, pslverr, er, ack, irq, uvalid, strobe, io_ack;
  logic [1:0] func;
  logic [35:0] instr, wdata, io_rd, rd, uout, uin = 36'h0;
  logic [6:0] pi;
  int n_fail = 0, num_checks = 0, cyc = 0;
  always #12.5 clk = ~clk;

  iobd_top #(.UNIT_CYCLES(UC), .CODE_RST(7'h00)) iobd_top_i (.REF_CLK(clk), .RST(rst),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .IO_STROBE(strobe), .IO_FUNC(func),
    .IO_INSTR(instr), .IO_WDATA(wdata), .IO_ACK(io_ack), .IO_RDATA(io_rd), .PI_REQ(pi),
    .UNIT_OUT_DATA(uout), .UNIT_OUT_VALID(uvalid), .UNIT_IN_DATA(uin), .IRQ(irq));
  iobd_cpu iobd_cpu_i (.clk(clk), .io_strobe(strobe), .io_func(func), .io_instr(instr),
    .io_wdata(wdata), .io_ack(io_ack), .io_rdata(io_rd));

  // ==========================================================================
  // Tasks
  task automatic chk_io(input logic [35:0] got, input logic [35:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_io
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    chk_io({4'h0, got}, {4'h0, exp});
  endtask : chk_reg
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rr = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd_reg(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk_reg(rr, exp);
  endtask : rd_reg
  task automatic io(input logic [1:0] fn, input logic [35:0] wd);
    iobd_cpu_i.op(fn, 7'h2a, wd, ack, rd);
  endtask : io
  task automatic chk_irq(input logic exp);
    repeat (2) @(negedge clk);
    chk_io({35'h0, irq}, {35'h0, exp});
  endtask : chk_irq
  // Polls done through conditions-in, bounded
  task automatic wait_done;
    for (int i = 0; i < 20; i++)
    begin
      io(2'h3, 36'h0);
      if (rd[1] === 1'b1)
        break;
    end
  endtask : wait_done
  task automatic close_out;
    $display("checks=%0d mismatches=%0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : close_out

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_fail++;
      close_out();
    end
  end

  // ==========================================================================
  // Tests
  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rd_reg(`IOBD_OFF_CONFIG, 32'h0);
    rd_reg(`IOBD_OFF_STATUS, 32'h0);
    rd_reg(12'h010, 32'h0);
    chk_io({35'h0, er}, 36'h1);
    apb(1'b1, `IOBD_OFF_CONFIG, 32'h2a);
    apb(1'b1, `IOBD_OFF_MASK, 32'h3);
    iobd_cpu_i.op(2'h0, 7'h15, 36'h1b, ack, rd);
    chk_io({35'h0, ack}, 36'h0);
    rd_reg(`IOBD_OFF_STATUS, 32'h0);
    io(2'h0, 36'h0b);
    chk_io({35'h0, ack}, 36'h1);
    rd_reg(`IOBD_OFF_STATUS, 32'h2c);
    $display("test select done");
    io(2'h1, 36'h9000000a5);
    io(2'h1, 36'h6000000c3);
    rd_reg(`IOBD_OFF_STATUS, 32'h2d);
    wait_done();
    chk_io({29'h0, pi}, 36'h04);
    rd_reg(`IOBD_OFF_STATUS, 32'h2e);
    chk_io(uout, 36'h9000000a5);
    rd_reg(`IOBD_OFF_EVENT, 32'h3);
    chk_irq(1'b1);
    apb(1'b1, `IOBD_OFF_EVENT, 32'h3);
    chk_irq(1'b0);
    io(2'h1, 36'h6000000c3);
    rd_reg(`IOBD_OFF_STATUS, 32'h2d);
    chk_io({29'h0, pi}, 36'h0);
    wait_done();
    chk_io(uout, 36'h6000000c3);
    $display("test output done");
    for (int n = 0; n < 8; n++)
    begin
      @(posedge clk) uin <= 36'h5a5a50000 + 36'(n);
      io(2'h0, 36'h10 | 36'(n));
      rd_reg(`IOBD_OFF_STATUS, 32'(n << 2) | 32'h1);
      wait_done();
      chk_io({29'h0, pi}, (n == 0) ? 36'h0 : 36'(1 << (n - 1)));
      io(2'h2, 36'h0);
      chk_io(rd, 36'h5a5a50000 + 36'(n));
      rd_reg(`IOBD_OFF_STATUS, 32'(n << 2));
      chk_io({29'h0, pi}, 36'h0);
    end
    io(2'h0, 36'h18);
    wait_done();
    chk_io({29'h0, pi}, 36'h0);
    rd_reg(`IOBD_OFF_STATUS, 32'h22);
    $display("test channels done");
    chk_irq(1'b1);
    apb(1'b1, `IOBD_OFF_MASK, 32'h0);
    chk_irq(1'b0);
    apb(1'b1, `IOBD_OFF_MASK, 32'h1);
    chk_irq(1'b1);
    apb(1'b1, `IOBD_OFF_EVENT, 32'h1);
    chk_irq(1'b0);
    $display("test interrupt done");
    close_out();
  end
endmodule : tb_iobd_top
